// >>> logic/sdps_pkg.sv
package sdps_pkg;

  // Command encodings as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_ACT     = 4'h3;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_MRS     = 4'h0;
  localparam logic [3:0] CMD_ZQ      = 4'h6;

  localparam int CLK_PERIOD_PS = 4000;

  // Default wait figures in ps, lock delay in cycles
  localparam int BURST_TIME_PS            = 16000;
  localparam int PRECHARGE_PERIOD_PS      = 15000;
  localparam int REFRESH_CYCLE_TIME_PS    = 110000;
  localparam int SELF_REFRESH_EXIT_DELAY_PS = 120000;
  localparam int POWER_DOWN_EXIT_DELAY_PS = 24000;
  localparam int LOCK_DELAY_CYCLES        = 512;

  localparam int WAIT_W = 10;

  function automatic logic [WAIT_W-1:0] ps_to_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return WAIT_W'(c);
  endfunction : ps_to_cycles

  typedef enum logic [2:0] {
    SDPS_IDLE,
    SDPS_ACTIVE,
    SDPS_PRECH_PD,
    SDPS_ACTIVE_PD,
    SDPS_SELF_REFRESH
  } sdps_state_t;

endpackage : sdps_pkg

// >>> logic/sdps_power_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sdps_power_ctrl #(
  parameter int BANKS = 8
) (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   clock_enable,
  input  wire logic [3:0]             command,
  input  wire logic [$clog2(BANKS)-1:0] bank_addr,
  input  wire logic                   all_banks_flag,
  input  wire logic                   termination_control,
  output logic [2:0]                  power_state,
  output logic                        device_idle,
  output logic                        self_refresh_active,
  output logic                        power_down_active,
  output logic                        termination_enable,
  output logic                        illegal_seq,
  output logic                        refresh_pulse
);

  localparam logic [sdps_pkg::WAIT_W-1:0] BURST_CYC =
    sdps_pkg::ps_to_cycles(sdps_pkg::BURST_TIME_PS);
  localparam logic [sdps_pkg::WAIT_W-1:0] PRE_CYC =
    sdps_pkg::ps_to_cycles(sdps_pkg::PRECHARGE_PERIOD_PS);
  localparam logic [sdps_pkg::WAIT_W-1:0] RFC_CYC =
    sdps_pkg::ps_to_cycles(sdps_pkg::REFRESH_CYCLE_TIME_PS);
  localparam logic [sdps_pkg::WAIT_W-1:0] XS_CYC =
    sdps_pkg::ps_to_cycles(sdps_pkg::SELF_REFRESH_EXIT_DELAY_PS);
  localparam logic [sdps_pkg::WAIT_W-1:0] XP_CYC =
    sdps_pkg::ps_to_cycles(sdps_pkg::POWER_DOWN_EXIT_DELAY_PS);
  localparam logic [sdps_pkg::WAIT_W-1:0] LOCK_CYC =
    sdps_pkg::WAIT_W'(sdps_pkg::LOCK_DELAY_CYCLES);

  logic [1:0]                  cke_sync_ff;
  logic                        cke_prev_ff;
  logic [1:0]                  sr_exit_sync_ff;
  logic                        sr_exit_req_ff;
  sdps_pkg::sdps_state_t       state_ff, nxt_state;
  logic [BANKS-1:0]            open_ff, nxt_open;
  logic [sdps_pkg::WAIT_W-1:0] wait_ff, nxt_wait;
  logic [sdps_pkg::WAIT_W-1:0] burst_ff, nxt_burst;
  logic [sdps_pkg::WAIT_W-1:0] lock_ff, nxt_lock;
  logic [2:0]                  power_state_ff;
  logic                        idle_ff, nxt_idle;
  logic                        illegal_ff, nxt_illegal;
  logic                        refresh_ff, nxt_refresh;
  logic                        term_ff, nxt_term;
  logic                        cke_now;
  logic                        is_nop;
  logic                        sr_seen_ff;
  logic                        sr_wake;
  logic                        sr_flag_ff, nxt_sr_flag;
  logic                        pd_flag_ff, nxt_pd_flag;

  function automatic logic [sdps_pkg::WAIT_W-1:0] dec(input logic [sdps_pkg::WAIT_W-1:0] v);
    return (v != '0) ? v - 1'b1 : v;
  endfunction : dec

  always_ff @(posedge clock_enable or negedge resetn) begin
    if (!resetn) begin
      sr_exit_req_ff <= 1'b0;
    end else begin
      sr_exit_req_ff <= ~sr_exit_req_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cke_sync_ff     <= '0;
      cke_prev_ff     <= 1'b0;
      sr_exit_sync_ff <= '0;
      sr_seen_ff      <= 1'b0;
    end else begin
      cke_sync_ff     <= {cke_sync_ff[0], clock_enable};
      cke_prev_ff     <= cke_sync_ff[1];
      sr_exit_sync_ff <= {sr_exit_sync_ff[0], sr_exit_req_ff};
      sr_seen_ff      <= sr_exit_sync_ff[1];
    end
  end

  assign cke_now = cke_sync_ff[1];
  assign is_nop  = command[3] | (command == sdps_pkg::CMD_NOP);
  // Toggle change marks a rising clock enable
  assign sr_wake = sr_exit_sync_ff[1] ^ sr_seen_ff;

  always_comb begin
    nxt_state   = state_ff;
    nxt_open    = open_ff;
    nxt_wait    = dec(wait_ff);
    nxt_burst   = dec(burst_ff);
    nxt_lock    = dec(lock_ff);
    nxt_illegal = 1'b0;
    nxt_refresh = 1'b0;
    // action from previous, current and command
    unique case (state_ff)
      sdps_pkg::SDPS_PRECH_PD, sdps_pkg::SDPS_ACTIVE_PD: begin
        if (cke_now) begin
          if (is_nop) begin
            nxt_state = (open_ff == '0) ? sdps_pkg::SDPS_IDLE : sdps_pkg::SDPS_ACTIVE;
            nxt_wait  = XP_CYC;
          end else begin
            nxt_illegal = 1'b1;
          end
        end
      end
      sdps_pkg::SDPS_SELF_REFRESH: begin
        if (cke_now || sr_wake) begin
          nxt_state = sdps_pkg::SDPS_IDLE;
          nxt_wait  = XS_CYC;
          nxt_lock  = LOCK_CYC;
          nxt_illegal = ~is_nop;
        end
      end
      default: begin
        if (cke_prev_ff && !cke_now) begin
          if (command == sdps_pkg::CMD_REFRESH && state_ff == sdps_pkg::SDPS_IDLE
              && idle_ff) begin
            nxt_state = sdps_pkg::SDPS_SELF_REFRESH;
          end else if (is_nop) begin
            nxt_state = (open_ff == '0) ? sdps_pkg::SDPS_PRECH_PD
                                        : sdps_pkg::SDPS_ACTIVE_PD;
          end else begin
            nxt_illegal = 1'b1;
          end
        end else if (cke_now) begin
          unique case (command)
            sdps_pkg::CMD_ACT:     nxt_open[bank_addr] = 1'b1;
            sdps_pkg::CMD_PRE: begin
              if (all_banks_flag) begin
                nxt_open = '0;
              end else begin
                nxt_open[bank_addr] = 1'b0;
              end
              nxt_wait = PRE_CYC;
            end
            sdps_pkg::CMD_READ, sdps_pkg::CMD_WRITE: begin
              nxt_burst = BURST_CYC;
              if (all_banks_flag) begin
                nxt_open[bank_addr] = 1'b0;
              end
            end
            sdps_pkg::CMD_REFRESH: begin
              nxt_wait    = RFC_CYC;
              nxt_refresh = 1'b1;
            end
            default: begin
            end
          endcase
          nxt_state = (nxt_open == '0) ? sdps_pkg::SDPS_IDLE : sdps_pkg::SDPS_ACTIVE;
        end
      end
    endcase
    // idle needs closed, no burst, waits expired
    nxt_idle = (nxt_state == sdps_pkg::SDPS_IDLE) && (nxt_open == '0) &&
               (nxt_burst == '0) && (nxt_wait == '0) && cke_now;
    nxt_term = termination_control && (nxt_state != sdps_pkg::SDPS_SELF_REFRESH)
               && (nxt_lock == '0);
    nxt_sr_flag = (nxt_state == sdps_pkg::SDPS_SELF_REFRESH);
    nxt_pd_flag = (nxt_state == sdps_pkg::SDPS_PRECH_PD) ||
                  (nxt_state == sdps_pkg::SDPS_ACTIVE_PD);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff       <= sdps_pkg::SDPS_IDLE;
      open_ff        <= '0;
      wait_ff        <= '0;
      burst_ff       <= '0;
      lock_ff        <= '0;
      power_state_ff <= '0;
      idle_ff        <= 1'b0;
      illegal_ff     <= 1'b0;
      refresh_ff     <= 1'b0;
      term_ff        <= 1'b0;
      sr_flag_ff     <= 1'b0;
      pd_flag_ff     <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      open_ff        <= nxt_open;
      wait_ff        <= nxt_wait;
      burst_ff       <= nxt_burst;
      lock_ff        <= nxt_lock;
      power_state_ff <= 3'(nxt_state);
      idle_ff        <= nxt_idle;
      illegal_ff     <= nxt_illegal;
      refresh_ff     <= nxt_refresh;
      term_ff        <= nxt_term;
      sr_flag_ff     <= nxt_sr_flag;
      pd_flag_ff     <= nxt_pd_flag;
    end
  end

  assign power_state         = power_state_ff;
  assign device_idle         = idle_ff;
  assign self_refresh_active = sr_flag_ff;
  assign power_down_active   = pd_flag_ff;
  assign termination_enable  = term_ff;
  assign illegal_seq         = illegal_ff;
  assign refresh_pulse       = refresh_ff;

endmodule : sdps_power_ctrl
`default_nettype wire

// >>> bench/sdps_power_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module sdps_chk (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       clock_enable,
  input wire logic [3:0] command,
  input wire logic [2:0] power_state,
  input wire logic       device_idle,
  input wire logic       self_refresh_active,
  input wire logic       power_down_active,
  input wire logic       termination_enable,
  input wire logic       illegal_seq,
  input wire logic       refresh_pulse
);
  logic [2:0] lo_ff;
  logic [2:0] nxt_lo;
  logic       no_operation_command;
  assign no_operation_command = command[3] || command == sdps_pkg::CMD_NOP;
  always_comb begin
    nxt_lo = clock_enable ? 3'h0 : (lo_ff == 3'h7 ? lo_ff : lo_ff + 3'h1);
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lo_ff <= 3'h0;
    end else begin
      lo_ff <= nxt_lo;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sr_decode_a: assert property (
    self_refresh_active == (power_state == 3'h4)) else $error("self refresh flag");
  pd_decode_a: assert property (
    power_down_active == (power_state inside {3'h2, 3'h3})) else $error("power down flag");
  pd_hold_a: assert property (
    power_down_active && lo_ff == 3'h7 |=> power_down_active && !refresh_pulse)
    else $error("power down left");
  sr_hold_a: assert property (
    self_refresh_active && lo_ff == 3'h7 |=> self_refresh_active) else $error("sr left");
  term_off_a: assert property (
    self_refresh_active && $past(self_refresh_active) |-> !termination_enable)
    else $error("termination on");
  pd_entry_a: assert property (
    $fell(clock_enable) && device_idle && no_operation_command ##1 (!clock_enable && no_operation_command) [*2]
    |=> power_state == 3'h2) else $error("no power down entry");
  sr_entry_a: assert property (
    $fell(clock_enable) && device_idle && no_operation_command ##1 !clock_enable && no_operation_command ##1
    !clock_enable && command == sdps_pkg::CMD_REFRESH |=> power_state == 3'h4)
    else $error("no self refresh entry");
  pd_exit_a: assert property (
    $rose(clock_enable) && power_down_active && no_operation_command ##1 (clock_enable && no_operation_command) [*2]
    |=> !power_down_active) else $error("no power down exit");
  bad_entry_a: assert property (
    $fell(clock_enable) && device_idle && no_operation_command ##1 !clock_enable && no_operation_command ##1
    !clock_enable && command == sdps_pkg::CMD_ACT |=> illegal_seq) else $error("no flag");
endmodule : sdps_chk
bind sdps_power_ctrl sdps_chk i_sdps_chk (.sys_clk(sys_clk), .resetn(resetn),
  .clock_enable(clock_enable), .command(command), .power_state(power_state),
  .device_idle(device_idle), .self_refresh_active(self_refresh_active),
  .power_down_active(power_down_active), .termination_enable(termination_enable),
  .illegal_seq(illegal_seq), .refresh_pulse(refresh_pulse));
`default_nettype wire

// >>> bench/sdps_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdps_ctrl_model #(
  parameter int HOLD = 32
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       want_cke,
  input  wire logic [3:0] want_cmd,
  input  wire logic       raw,
  output var logic        clock_enable,
  output var logic  [3:0] command
);
  int hold_cnt;
  always @(negedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clock_enable <= 1'b1;
      command <= sdps_pkg::CMD_NOP;
      hold_cnt <= 0;
    end else begin
      if (want_cke !== clock_enable && hold_cnt == 0) begin
        clock_enable <= want_cke;
        hold_cnt <= HOLD;
      end else if (hold_cnt > 0) begin
        hold_cnt <= hold_cnt - 1;
      end
      command <= (raw || (hold_cnt == 0 && want_cke === clock_enable)) ? want_cmd
                                                                      : sdps_pkg::CMD_NOP;
    end
  end
endmodule : sdps_ctrl_model
`default_nettype wire

// >>> bench/sdps_power_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sdps_power_ctrl_tb;
  logic       sys_clk, resetn, want_cke, raw, clock_enable, all_banks_flag;
  logic [3:0] want_cmd, command;
  logic [2:0] bank_addr, power_state;
  logic       device_idle, self_refresh_active, power_down_active;
  logic       termination_control, termination_enable, illegal_seq, refresh_pulse;
  int         mismatches, n_tests, cyc, n_ill, n_ref, r0;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  sdps_ctrl_model i_sdps_ctrl_model (.sys_clk(sys_clk), .resetn(resetn), .want_cke(want_cke),
    .want_cmd(want_cmd), .raw(raw), .clock_enable(clock_enable), .command(command));
  sdps_power_ctrl i_sdps_power_ctrl (.sys_clk(sys_clk), .resetn(resetn),
    .clock_enable(clock_enable), .command(command), .bank_addr(bank_addr),
    .all_banks_flag(all_banks_flag), .termination_control(termination_control),
    .power_state(power_state), .device_idle(device_idle),
    .self_refresh_active(self_refresh_active), .power_down_active(power_down_active),
    .termination_enable(termination_enable), .illegal_seq(illegal_seq),
    .refresh_pulse(refresh_pulse));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    n_ill <= n_ill + int'(illegal_seq === 1'b1);
    n_ref <= n_ref + int'(refresh_pulse === 1'b1);
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] pd_code(input logic any_open);
    return any_open ? 8'h03 : 8'h02;
  endfunction : pd_code
  task automatic step(input logic cke, input logic [3:0] cmd, input logic r, input int n);
    @(negedge sys_clk);
    want_cke <= cke;
    want_cmd <= cmd;
    raw <= r;
    repeat (n - 1) @(negedge sys_clk);
  endtask : step
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {mismatches, n_tests, cyc, n_ill, n_ref} = '0;
    {resetn, raw, all_banks_flag, bank_addr} = '0;
    {want_cke, termination_control, want_cmd} = {2'h3, sdps_pkg::CMD_NOP};
    void'($urandom(21502));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 40);
    step(1'b0, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'(power_state), pd_code(1'b0));
    chk(8'({device_idle, self_refresh_active, power_down_active}), 8'h01);
    for (int i = 0; i < 20; i++) begin
      bank_addr = 3'($urandom);
      step(1'b0, 4'($urandom), 1'b1, 1);
      chk(8'({power_state, refresh_pulse}), 8'h04);
    end
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'(power_state), 8'h00);
    step(1'b1, sdps_pkg::CMD_MRS, 1'b0, 1);
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 10);
    step(1'b0, sdps_pkg::CMD_NOP, 1'b1, 2);
    step(1'b0, sdps_pkg::CMD_REFRESH, 1'b1, 1);
    step(1'b0, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'({power_state, termination_enable}), 8'h08);
    chk(8'({device_idle, self_refresh_active, power_down_active}), 8'h02);
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'({power_state, termination_enable}), 8'h00);
    repeat (600) @(negedge sys_clk);
    chk(8'(termination_enable), 8'h01);
    r0 = n_ref;
    step(1'b1, sdps_pkg::CMD_REFRESH, 1'b0, 1);
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'(n_ref - r0), 8'h01);
    step(1'b0, sdps_pkg::CMD_NOP, 1'b1, 2);
    step(1'b0, sdps_pkg::CMD_ACT, 1'b1, 1);
    step(1'b0, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'(n_ill > 0), 8'h01);
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 40);
    bank_addr = 3'($urandom);
    step(1'b1, sdps_pkg::CMD_ACT, 1'b0, 10);
    step(1'b0, sdps_pkg::CMD_NOP, 1'b0, 40);
    chk(8'(power_state), pd_code(1'b1));
    chk(8'({device_idle, self_refresh_active, power_down_active}), 8'h01);
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 40);
    all_banks_flag = 1'b1;
    step(1'b1, sdps_pkg::CMD_PRE, 1'b0, 1);
    step(1'b1, sdps_pkg::CMD_NOP, 1'b0, 20);
    chk(8'(power_state), 8'h00);
    chk(8'(device_idle), 8'h01);
    tally_and_finish();
  end
endmodule : sdps_power_ctrl_tb
`default_nettype wire
